// ==== common/adcsr_pkg.sv ====
// Shared constants, commands and types of the ADC status and ready block
package adcsr_pkg;

   // Command bytes carried after the target address
   localparam logic [7:0] CMD_POWER_DOWN = 8'h02;
   localparam logic [7:0] CMD_SOFT_RESET = 8'h06;
   localparam logic [7:0] CMD_START_SYNC = 8'h08;
   localparam logic [7:0] CMD_READ_DATA  = 8'h10;
   localparam logic [7:0] CMD_REG_READ   = 8'h20;
   localparam logic [7:0] CMD_REG_WRITE  = 8'h40;
   localparam logic [7:0] CMD_REG_MASK   = 8'hF8;
   localparam int         CMD_REG_SEL_BIT = 2;

   // Register indices and layout
   localparam logic       REG_CONFIG_IDX    = 1'h0;
   localparam logic       REG_STATUS_IDX    = 1'h1;
   localparam logic [7:0] CONFIG_RESET      = 8'h00;
   localparam logic       READY_FLAG_RESET  = 1'h0;
   localparam int         STATUS_READY_BIT  = 7;
   localparam logic [6:0] STATUS_RSVD_VALUE = 7'h00;

   // Target address base, low four bits come from the straps
   localparam logic [6:0] TARGET_ADDR_BASE = 7'h40;

   // Bit and byte counting
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam int         RESULT_WIDTH  = 16;

   // Sampled two-wire bus lines
   typedef struct packed {
      logic scl;
      logic sda;
   } adcsr_bus_t;

   // Target protocol states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_CMD,
      ST_WDATA,
      ST_ACK,
      ST_READ,
      ST_RACK
   } adcsr_state_t;

endpackage

// ==== rtl/adcsr_sync.sv ====
// Two-flop synchroniser for pin inputs of the ADC status block
`timescale 1ns/1ps
module adcsr_sync #(
   parameter int         WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // Clock and reset
   input  wire logic             i_sys_clk,
   input  wire logic             i_rst_n,
   // Asynchronous levels in, synchronised levels out
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         meta_q <= RESET_VAL;
         o_sync <= RESET_VAL;
      end
      else
      begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end

endmodule

// ==== rtl/adcsr_status_ready.sv ====
// Two-wire target with conversion status register and ready pin
`timescale 1ns/1ps
module adcsr_status_ready
   import adcsr_pkg::*;
#(
   parameter logic [6:0] ADDR_BASE = adcsr_pkg::TARGET_ADDR_BASE,
   parameter int         RES_W     = adcsr_pkg::RESULT_WIDTH
) (
   // Clock and reset
   input  wire logic             i_sys_clk,
   input  wire logic             i_rst_n,
   // Two-wire bus pins, data line open drain
   input  wire logic             i_scl,
   input  wire logic             i_sda,
   output logic                  o_sda_o,
   output logic                  o_sda_oe,
   // Address strap codes, one of four levels each
   input  wire logic [1:0]       i_address_select_low_pin,
   input  wire logic [1:0]       i_address_select_high_pin,
   // Converter side, same clock
   input  wire logic             i_result_valid,
   input  wire logic [RES_W-1:0] i_result,
   output logic      [7:0]       o_config,
   output logic                  o_start_conv,
   output logic                  o_power_down,
   output logic                  o_soft_reset,
   // Ready pin, open drain
   output logic                  o_ready_pin_o,
   output logic                  o_ready_pin_oe
);
   import adcsr_pkg::*;

   adcsr_bus_t       bus_s;
   adcsr_bus_t       bus_p_q;
   logic [1:0]       strap_lo;
   logic [1:0]       strap_hi;
   adcsr_state_t     st_q;
   adcsr_state_t     st_d;
   adcsr_state_t     after_q;
   adcsr_state_t     after_d;
   logic [3:0]       cnt_q;
   logic [3:0]       cnt_d;
   logic [7:0]       sh_q;
   logic [7:0]       sh_d;
   logic             drive_q;
   logic             drive_d;
   logic             wsel_q;
   logic [7:0]       cfg_q;
   logic             ready_q;
   logic [RES_W-1:0] hold_q;
   logic [RES_W-1:0] tx_q;
   logic             start_q;
   logic             pdown_q;
   logic             sreset_q;

   // Pins pass two flops before any logic
   adcsr_sync #(
      .WIDTH     (6),
      .RESET_VAL (6'h03)
   ) u_sync (
      .i_sys_clk (i_sys_clk),
      .i_rst_n   (i_rst_n),
      .i_async   ({i_address_select_high_pin, i_address_select_low_pin,
                   i_scl, i_sda}),
      .o_sync    ({strap_hi, strap_lo, bus_s})
   );

   // Previous bus sample for edge and condition detection
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         bus_p_q <= '{scl: 1'b1, sda: 1'b1};
      else
         bus_p_q <= bus_s;
   end

   // Bus events
   wire scl_rise  = bus_s.scl & ~bus_p_q.scl;
   wire scl_fall  = ~bus_s.scl & bus_p_q.scl;
   wire bus_start = bus_s.scl & bus_p_q.scl & bus_p_q.sda & ~bus_s.sda;
   wire bus_stop  = bus_s.scl & bus_p_q.scl & ~bus_p_q.sda & bus_s.sda;

   // Own address from straps, sixteen choices
   wire [6:0] own_addr = ADDR_BASE | {3'h0, strap_hi, strap_lo};

   // Byte completion and command decode
   wire rx_state   = (st_q == ST_ADDR) || (st_q == ST_CMD) ||
                     (st_q == ST_WDATA);
   wire byte_done  = rx_state && scl_fall && (cnt_q == BITS_PER_BYTE) &&
                     !bus_start && !bus_stop;
   wire addr_hit   = (sh_q[7:1] == own_addr);
   wire cmd_done   = byte_done && (st_q == ST_CMD);
   wire cmd_rdata  = cmd_done && (sh_q == CMD_READ_DATA);
   wire cmd_reset  = cmd_done && (sh_q == CMD_SOFT_RESET);
   wire cmd_start  = cmd_done && (sh_q == CMD_START_SYNC);
   wire cmd_pdown  = cmd_done && (sh_q == CMD_POWER_DOWN);
   wire cmd_register_read_command   = cmd_done && ((sh_q & CMD_REG_MASK) == CMD_REG_READ);
   wire cmd_register_write_command   = cmd_done && ((sh_q & CMD_REG_MASK) == CMD_REG_WRITE);
   wire reg_sel    = sh_q[CMD_REG_SEL_BIT];
   wire wdata_done = byte_done && (st_q == ST_WDATA);
   wire tx_load    = (st_q == ST_ACK) && scl_fall && (after_q == ST_READ) &&
                     !bus_start && !bus_stop;

   // Status byte: flag on top, reserved bits fixed low
   wire [7:0] status_byte = {ready_q, STATUS_RSVD_VALUE};
   wire [7:0] reg_rd_byte = (reg_sel == REG_STATUS_IDX) ? status_byte
                                                        : cfg_q;

   // Target protocol next state
   always_comb
   begin
      st_d    = st_q;
      after_d = after_q;
      cnt_d   = cnt_q;
      sh_d    = sh_q;
      drive_d = drive_q;
      if (bus_stop)
      begin
         st_d    = ST_IDLE;
         drive_d = 1'b0;
      end
      else if (bus_start)
      begin
         st_d    = ST_ADDR;
         cnt_d   = 4'h0;
         drive_d = 1'b0;
      end
      else
      begin
         unique case (st_q)
            ST_IDLE:
               st_d = ST_IDLE;
            ST_ADDR, ST_CMD, ST_WDATA:
               if (scl_rise)
               begin
                  sh_d  = {sh_q[6:0], bus_s.sda};
                  cnt_d = cnt_q + 4'h1;
               end
               else if (byte_done)
               begin
                  st_d    = ST_ACK;
                  drive_d = 1'b1;
                  after_d = ST_CMD;
                  if (st_q == ST_ADDR)
                  begin
                     if (!addr_hit)
                     begin
                        st_d    = ST_IDLE;
                        drive_d = 1'b0;
                     end
                     else if (sh_q[0])
                        after_d = ST_READ;
                  end
                  else if (cmd_register_write_command)
                     after_d = ST_WDATA;
               end
            ST_ACK:
               if (scl_fall)
               begin
                  st_d    = after_q;
                  cnt_d   = 4'h0;
                  drive_d = 1'b0;
                  if (after_q == ST_READ)
                  begin
                     sh_d    = tx_q[RES_W-1 -: 8];
                     drive_d = ~tx_q[RES_W-1];
                  end
               end
            ST_READ:
               if (scl_rise)
                  cnt_d = cnt_q + 4'h1;
               else if (scl_fall)
               begin
                  if (cnt_q == BITS_PER_BYTE)
                  begin
                     st_d    = ST_RACK;
                     drive_d = 1'b0;
                  end
                  else
                  begin
                     sh_d    = {sh_q[6:0], 1'b0};
                     drive_d = ~sh_q[6];
                  end
               end
            ST_RACK:
               if (scl_rise)
               begin
                  if (bus_s.sda)
                     st_d = ST_IDLE;
                  else
                  begin
                     st_d    = ST_ACK;
                     after_d = ST_READ;
                  end
               end
         endcase
      end
   end

   // Protocol registers; data line changes only after clock falls
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         st_q    <= ST_IDLE;
         after_q <= ST_IDLE;
         cnt_q   <= 4'h0;
         sh_q    <= 8'h00;
         drive_q <= 1'b0;
      end
      else
      begin
         st_q    <= st_d;
         after_q <= after_d;
         cnt_q   <= cnt_d;
         sh_q    <= sh_d;
         drive_q <= drive_d;
      end
   end

   // Configuration register and register write select
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cfg_q  <= CONFIG_RESET;
         wsel_q <= REG_CONFIG_IDX;
      end
      else
      begin
         if (cmd_register_write_command)
            wsel_q <= reg_sel;
         if (cmd_reset)
            cfg_q <= CONFIG_RESET;
         else if (wdata_done && (wsel_q == REG_CONFIG_IDX))
            cfg_q <= sh_q;
      end
   end

   // Ready flag: new result wins over a clearing read
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         ready_q <= READY_FLAG_RESET;
      else if (i_result_valid)
         ready_q <= 1'b1;
      else if (cmd_rdata || cmd_reset)
         ready_q <= 1'b0;
   end

   // Result holding and output shift; a result never disturbs a read
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         hold_q <= '0;
         tx_q   <= '0;
      end
      else
      begin
         if (i_result_valid)
            hold_q <= i_result;
         if (cmd_rdata)
            tx_q <= hold_q;
         else if (cmd_register_read_command)
            tx_q <= {reg_rd_byte, {(RES_W-8){1'b0}}};
         else if (tx_load)
            tx_q <= {tx_q[RES_W-9:0], 8'h00};
      end
   end

   // One-cycle command pulses to the converter
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         start_q  <= 1'b0;
         pdown_q  <= 1'b0;
         sreset_q <= 1'b0;
      end
      else
      begin
         start_q  <= cmd_start;
         pdown_q  <= cmd_pdown;
         sreset_q <= cmd_reset;
      end
   end

   // Pin drivers; no clock line output exists at all
   assign o_sda_o        = 1'b0;
   assign o_sda_oe       = drive_q;
   assign o_ready_pin_o  = 1'b0;
   assign o_ready_pin_oe = ready_q;
   assign o_config       = cfg_q;
   assign o_start_conv   = start_q;
   assign o_power_down   = pdown_q;
   assign o_soft_reset   = sreset_q;

   // Checks
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_new_result;
      i_result_valid;
   endsequence

   sequence s_clearing_read;
      cmd_rdata && !i_result_valid;
   endsequence

   chk_flag_set_wins: assert property (
      s_new_result |=> ready_q ##0 status_byte[STATUS_READY_BIT])
      else $error("ready flag not set by new result");
   chk_flag_read_clear: assert property (
      s_clearing_read |=> !ready_q && (tx_q == $past(hold_q)))
      else $error("read-data did not clear flag or load result");
   chk_status_readback: assert property (
      cmd_register_read_command && reg_sel && !i_result_valid |=>
      tx_q[RES_W-1 -: 8] == {ready_q, 7'h00})
      else $error("status read returned wrong byte");
   chk_soft_reset_zero: assert property (
      cmd_reset && !i_result_valid |=> !ready_q && cfg_q == CONFIG_RESET &&
      o_soft_reset ##1 !o_soft_reset)
      else $error("reset command left state set");
   chk_sda_drive_low: assert property (
      $rose(o_sda_oe) |-> !bus_s.scl && !o_sda_o)
      else $error("data line driven while clock high");
   chk_addr_miss_idle: assert property (
      byte_done && st_q == ST_ADDR && !addr_hit |=>
      st_q == ST_IDLE && !o_sda_oe)
      else $error("foreign address acknowledged");
   chk_ready_pin_low: assert property (
      s_new_result |=> o_ready_pin_oe && !o_ready_pin_o)
      else $error("ready pin not pulled low on new result");
   chk_result_isolated: assert property (
      i_result_valid && !cmd_rdata && !cmd_register_read_command && !tx_load |=>
      $stable(tx_q))
      else $error("new result disturbed output data");
   chk_config_write: assert property (
      wdata_done && wsel_q == REG_CONFIG_IDX && !cmd_reset |=>
      o_config == $past(sh_q))
      else $error("register write not applied");

endmodule

// ==== testbench/adcsr_host_model.sv ====
// Two-wire bus controller model facing the status block
`timescale 1ns/1ps
module adcsr_host_model (
   // Clock and bus lines
   input  wire logic       i_sys_clk,
   input  wire logic       i_sda,
   output logic            o_scl,
   output logic            o_sda_pull,
   // Each byte read back
   output logic            o_rd_stb,
   output logic [7:0]      o_rd_byte
);
   int q = 25;

   // Idle bus, both lines released
   initial
   begin
      o_scl      = 1'b1;
      o_sda_pull = 1'b0;
      o_rd_stb   = 1'b0;
      o_rd_byte  = 8'h00;
   end

   task automatic hold(input int n);
      repeat (n) @(negedge i_sys_clk);
   endtask

   // One bit: data set mid-low, sampled mid-high
   task automatic bit_io(input logic b, output logic s);
      hold(q);
      o_sda_pull = ~b;
      hold(q);
      o_scl = 1'b1;
      hold(q);
      s = i_sda;
      hold(q);
      o_scl = 1'b0;
   endtask

   // Start or repeated start
   task automatic start();
      hold(q);
      o_sda_pull = 1'b0;
      hold(q);
      o_scl = 1'b1;
      hold(q);
      o_sda_pull = 1'b1;
      hold(q);
      o_scl = 1'b0;
   endtask

   // Stop, clock left standing high
   task automatic stop();
      hold(q);
      o_sda_pull = 1'b1;
      hold(q);
      o_scl = 1'b1;
      hold(q);
      o_sda_pull = 1'b0;
      hold(q);
   endtask

   // Byte out, then sample the target's acknowledge
   task automatic wbyte(input logic [7:0] b, output logic ack_n);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_io(b[i], s);
      bit_io(1'b1, ack_n);
   endtask

   // Byte in, then acknowledge or end with a NACK
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(1'b1, s);
         d[i] = s;
      end
      o_rd_byte = d;
      o_rd_stb  = 1'b1;
      hold(1);
      o_rd_stb  = 1'b0;
      bit_io(last, s);
   endtask
endmodule

// ==== testbench/adcsr_status_ready_tb.sv ====
// Self-checking bench for the ADC status and ready block
`timescale 1ns/1ps
module adcsr_status_ready_tb;
   import adcsr_pkg::*;
   localparam int LIMIT = 90000;
   logic        i_sys_clk;
   logic        i_rst_n;
   logic        i_result_valid;
   logic [15:0] i_result;
   logic [1:0]  strap_lo;
   logic [1:0]  strap_hi;
   logic        scl;
   logic        sda_pull;
   logic        sda_o;
   logic        sda_oe;
   logic        rdy_o;
   logic        rdy_oe;
   logic        rd_stb;
   logic        ack_n;
   logic [7:0]  rd_byte;
   logic [7:0]  cfg_out;
   logic        start_conv;
   logic        pdown;
   logic        sreset;
   logic [7:0]  n_start = 8'h00;
   logic [7:0]  n_pdown = 8'h00;
   logic [7:0]  n_sreset = 8'h00;
   logic [7:0]  got;
   logic [7:0]  cfg_v;
   logic [15:0] res;
   logic [15:0] nxt;
   logic [15:0] exp_q[$];
   int          error_cnt = 0;
   int          n_checks = 0;
   int          cyc = 0;
   int          spd[3] = '{250, 62, 25};
   wire logic       bus_sda;
   wire logic       rdy_lvl;
   wire logic [6:0] addr;

   // Open-drain lines with pull-ups, address from straps
   assign bus_sda = ~(sda_pull | (sda_oe & ~sda_o));
   assign rdy_lvl = ~(rdy_oe & ~rdy_o);
   assign addr    = TARGET_ADDR_BASE | {3'h0, strap_hi, strap_lo};

   adcsr_status_ready dut (
      .i_sys_clk                 (i_sys_clk),
      .i_rst_n                   (i_rst_n),
      .i_scl                     (scl),
      .i_sda                     (bus_sda),
      .o_sda_o                   (sda_o),
      .o_sda_oe                  (sda_oe),
      .i_address_select_low_pin  (strap_lo),
      .i_address_select_high_pin (strap_hi),
      .i_result_valid            (i_result_valid),
      .i_result                  (i_result),
      .o_config                  (cfg_out),
      .o_start_conv              (start_conv),
      .o_power_down              (pdown),
      .o_soft_reset              (sreset),
      .o_ready_pin_o             (rdy_o),
      .o_ready_pin_oe            (rdy_oe)
   );

   adcsr_host_model host (
      .i_sys_clk  (i_sys_clk),
      .i_sda      (bus_sda),
      .o_scl      (scl),
      .o_sda_pull (sda_pull),
      .o_rd_stb   (rd_stb),
      .o_rd_byte  (rd_byte)
   );

   task automatic summarize();
      if (error_cnt == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk1(input logic g, input logic e);
      n_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e);
      end
   endtask

   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e);
      end
   endtask

   // Note holds {mask, value}; reserved bits are masked off
   task automatic chk_byte(input logic [7:0] g);
      logic [15:0] e;
      e = (exp_q.size() > 0) ? exp_q.pop_front() : {8'hFF, ~g};
      n_checks++;
      if ((g & e[15:8]) !== e[7:0])
      begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e[7:0]);
      end
   endtask

   task automatic wr(input logic [7:0] b);
      host.wbyte(b, ack_n);
      chk1(ack_n, 1'b0);
   endtask

   task automatic probe(input logic [6:0] a, input logic e);
      host.start();
      host.wbyte({a, 1'b0}, ack_n);
      chk1(ack_n, e);
      host.stop();
   endtask

   task automatic read_back(input int n);
      host.start();
      wr({addr, 1'b1});
      for (int i = 0; i < n; i++)
         host.rbyte(i == n - 1, got);
      host.stop();
   endtask

   task automatic reg_read(input logic idx, input logic [15:0] e);
      exp_q.push_back(e);
      host.start();
      wr({addr, 1'b0});
      wr(CMD_REG_READ | {5'h0, idx, 2'h0});
      read_back(1);
   endtask

   task automatic data_cmd(input logic [15:0] v);
      exp_q.push_back({8'hFF, v[15:8]});
      exp_q.push_back({8'hFF, v[7:0]});
      host.start();
      wr({addr, 1'b0});
      wr(CMD_READ_DATA);
   endtask

   task automatic pulse(input logic [15:0] v);
      i_result       = v;
      i_result_valid = 1'b1;
      host.hold(1);
      i_result_valid = 1'b0;
   endtask

   // Clock
   initial
   begin
      i_sys_clk = 1'b0;
      forever #5 i_sys_clk = ~i_sys_clk;
   end

   // Hang guard
   always @(posedge i_sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == LIMIT)
      begin
         error_cnt++;
         summarize();
      end
   end

   // Compare each byte read back with the oldest note
   always @(posedge i_sys_clk)
      if (rd_stb === 1'b1)
         chk_byte(rd_byte);

   // Count one-cycle command pulses towards the converter
   always @(posedge i_sys_clk)
   begin
      if (start_conv === 1'b1)
         n_start <= n_start + 8'h01;
      if (pdown === 1'b1)
         n_pdown <= n_pdown + 8'h01;
      if (sreset === 1'b1)
         n_sreset <= n_sreset + 8'h01;
   end

   // Main sequence
   initial
   begin
      i_rst_n        = 1'b0;
      i_result_valid = 1'b0;
      i_result       = 16'h0000;
      strap_lo       = 2'h0;
      strap_hi       = 2'h0;
      void'($urandom(3068));
      host.hold(10);
      i_rst_n = 1'b1;
      host.hold(4);
      chk1(rdy_lvl, 1'b1);
      reg_read(1'b1, 16'h8000);
      cfg_v = 8'($urandom);
      host.start();
      wr({addr, 1'b0});
      wr(CMD_REG_WRITE);
      wr(cfg_v);
      host.stop();
      reg_read(1'b0, {8'hFF, cfg_v});
      chk8(cfg_out, cfg_v);
      host.start();
      wr({addr, 1'b0});
      wr(CMD_START_SYNC);
      wr(CMD_POWER_DOWN);
      host.stop();
      host.hold(4);
      chk8(n_start, 8'h01);
      chk8(n_pdown, 8'h01);
      chk8(cfg_out, cfg_v);
      res = 16'($urandom);
      pulse(res);
      host.hold(2);
      chk1(rdy_lvl, 1'b0);
      reg_read(1'b1, 16'h8080);
      reg_read(1'b1, 16'h8080);
      data_cmd(res);
      read_back(2);
      chk1(rdy_lvl, 1'b1);
      reg_read(1'b1, 16'h8000);
      res = 16'($urandom);
      nxt = 16'($urandom);
      pulse(res);
      data_cmd(res);
      fork
         read_back(2);
         begin
            host.hold(1500);
            pulse(nxt);
         end
      join
      chk1(rdy_lvl, 1'b0);
      data_cmd(nxt);
      read_back(2);
      pulse(res);
      host.start();
      wr({addr, 1'b0});
      wr(CMD_SOFT_RESET);
      host.stop();
      host.hold(4);
      chk1(rdy_lvl, 1'b1);
      chk8(n_sreset, 8'h01);
      chk8(cfg_out, CONFIG_RESET);
      reg_read(1'b1, 16'h8000);
      for (int i = 0; i < 3; i++)
      begin
         host.q = spd[i];
         probe(addr, 1'b0);
      end
      host.q = 25;
      for (int k = 0; k < 16; k++)
      begin
         {strap_hi, strap_lo} = k[3:0];
         host.hold(4);
         probe(addr, 1'b0);
      end
      probe(addr ^ 7'h10, 1'b1);
      host.hold(20);
      summarize();
   end
endmodule
